// ==== poll_pkg.sv ====
/*
  Shared constants for the drive-ready polling engine and the command
  handshake: register offsets, status bit positions, result codes,
  opcodes and scan timing.
  Assumes a 50 MHz pclk and 32-bit APB data with word-aligned registers.
*/
package poll_pkg;

  typedef enum logic [1:0] {
    PH_CMD    = 2'b00,
    PH_EXEC   = 2'b01,
    PH_RESULT = 2'b10
  } phase_t;

  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned SCAN_SHORT_US   = 220;
  localparam int unsigned SCAN_LONG_US    = 440;
  localparam int unsigned SCAN_SHORT_CYC  =
    (SCAN_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SCAN_LONG_CYC   =
    (SCAN_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned EXEC_CYC        = 16;

  localparam logic [11:0] MSR_OFFSET      = 12'h000;
  localparam logic [11:0] DATA_OFFSET     = 12'h004;
  localparam logic [11:0] DRIVE_OFFSET    = 12'h008;

  localparam int unsigned MSR_RQM_BIT     = 7;
  localparam int unsigned MSR_DIO_BIT     = 6;
  localparam int unsigned MSR_BUSY_BIT    = 4;
  localparam int unsigned ST0_NR_BIT      = 3;

  localparam logic [7:0]  ST0_INVALID     = 8'h80;
  localparam logic [7:0]  ST0_READY_CHG   = 8'hC0;
  localparam logic [7:0]  ST0_SEEK_END    = 8'h20;

  localparam logic [7:0]  OP_SENSE_INT    = 8'h08;
  localparam logic [7:0]  OP_RECAL        = 8'h07;

  localparam logic [1:0]  LAST_DRIVE      = 2'h3;

endpackage : poll_pkg

// ==== ready_sync.sv ====
/*
  Three-stage synchroniser for the drive ready pin with a two-stage
  agreement filter on the output level.
  Assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/1ps
module ready_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d    = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;

endmodule : ready_sync

// ==== ready_poll_cmd.sv ====
/*
  Drive-ready polling engine and command-phase handshake with an APB
  register slave: main status, data and drive status registers.
  Assumes one ready pin that reflects the currently selected drive, and
  an APB master that polls the main status register before each byte.
*/
`timescale 1ns/1ps
module ready_poll_cmd
  import poll_pkg::*;
#(
  parameter int unsigned SCAN_SHORT_CYCLES = SCAN_SHORT_CYC,
  parameter int unsigned SCAN_LONG_CYCLES  = SCAN_LONG_CYC,
  parameter int unsigned EXEC_CYCLES       = EXEC_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        drive_ready,
  output logic             drive_select_low,
  output logic             drive_select_high,
  output logic             int_req
);

  typedef struct packed {
    phase_t      phase;
    logic        byte_cnt;
    logic [7:0]  res0;
    logic [7:0]  res1;
    logic [1:0]  res_left;
    logic [15:0] exec_cnt;
    logic [1:0]  drive_sel;
    logic [15:0] slot_cnt;
    logic [3:0]  last_ready;
    logic [3:0]  seen;
    logic [3:0]  chg_pend;
    logic        seek_pend;
    logic [1:0]  seek_drive;
    logic        int_q;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] hold_cnt;
  } state_t;

  state_t     q;
  state_t     d;
  logic       rdy;
  logic [7:0] msr;
  logic       access;
  logic       data_wr;
  logic       data_rd;
  logic       found;
  logic [1:0] pick;

  ready_sync u_ready_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (drive_ready),
    .level    (rdy)
  );

  always_comb begin
    msr               = 8'h00;
    msr[MSR_RQM_BIT]  = (q.phase != PH_EXEC);
    msr[MSR_DIO_BIT]  = (q.phase != PH_CMD);
    msr[MSR_BUSY_BIT] = (q.phase != PH_CMD);
  end

  assign access  = psel & penable & q.pready;
  assign data_wr = access & pwrite & (paddr == DATA_OFFSET);
  assign data_rd = access & ~pwrite & (paddr == DATA_OFFSET);

  always_comb begin
    found = 1'b0;
    pick  = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (q.chg_pend[i]) begin
        found = 1'b1;
        pick  = 2'(i);
      end
    end
  end

  always_comb begin
    d         = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    // Answer in the second access cycle
    if (psel && penable && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      case (paddr)
        MSR_OFFSET:   d.prdata[7:0] = msr;
        DATA_OFFSET: begin
          if (q.phase == PH_RESULT) begin
            d.prdata[7:0] = q.res0;
          end
        end
        DRIVE_OFFSET: d.prdata[11:0] = {q.chg_pend, q.last_ready,
                                        2'b00, q.drive_sel};
        default:      d.pslverr = 1'b1;
      endcase
    end

    // Bytes are taken only while the status shows request and host-to-device
    if (data_wr && q.phase == PH_CMD) begin
      if (!q.byte_cnt) begin
        case (pwdata[7:0])
          OP_SENSE_INT: begin
            d.phase = PH_RESULT;
            d.res1  = 8'h00;
            if (found) begin
              d.res0             = ST0_READY_CHG | {6'h00, pick};
              d.res0[ST0_NR_BIT] = ~q.last_ready[pick];
              d.chg_pend[pick]   = 1'b0;
              d.res_left         = 2'd2;
            end else if (q.seek_pend) begin
              d.res0      = ST0_SEEK_END | {6'h00, q.seek_drive};
              d.seek_pend = 1'b0;
              d.res_left  = 2'd2;
            end else begin
              d.res0     = ST0_INVALID;
              d.res_left = 2'd1;
            end
          end
          OP_RECAL: d.byte_cnt = 1'b1;
          default: begin
            d.phase    = PH_RESULT;
            d.res0     = ST0_INVALID;
            d.res_left = 2'd1;
          end
        endcase
      end else begin
        d.byte_cnt   = 1'b0;
        d.seek_drive = pwdata[1:0];
        d.phase      = PH_EXEC;
        d.exec_cnt   = 16'(EXEC_CYCLES - 1);
      end
    end

    if (data_rd && q.phase == PH_RESULT) begin
      d.res0     = q.res1;
      d.res_left = q.res_left - 2'd1;
      if (q.res_left == 2'd1) begin
        d.phase = PH_CMD;
      end
    end

    if (q.phase == PH_EXEC) begin
      if (q.exec_cnt == 16'h0000) begin
        d.phase     = PH_CMD;
        d.seek_pend = 1'b1;
      end else begin
        d.exec_cnt = q.exec_cnt - 16'h0001;
      end
    end

    // Polling never stops; a new change wins over a sense clear above
    if (q.slot_cnt == 16'h0000) begin
      if (q.seen[q.drive_sel] && q.last_ready[q.drive_sel] != rdy) begin
        d.chg_pend[q.drive_sel] = 1'b1;
      end
      d.last_ready[q.drive_sel] = rdy;
      d.seen[q.drive_sel]       = 1'b1;
      d.drive_sel               = q.drive_sel + 2'h1;
      if (d.drive_sel == LAST_DRIVE) begin
        d.slot_cnt = 16'(SCAN_LONG_CYCLES - 1);
      end else begin
        d.slot_cnt = 16'(SCAN_SHORT_CYCLES - 1);
      end
    end else begin
      d.slot_cnt = q.slot_cnt - 16'h0001;
    end

    // Cycles the current select code has been held
    if (d.drive_sel != q.drive_sel) begin
      d.hold_cnt = 16'h0000;
    end else begin
      d.hold_cnt = q.hold_cnt + 16'h0001;
    end

    d.int_q = (|d.chg_pend) | d.seek_pend;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.slot_cnt <= 16'(SCAN_SHORT_CYCLES - 1);
    end else begin
      q <= d;
    end
  end

  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign drive_select_low  = q.drive_sel[0];
  assign drive_select_high = q.drive_sel[1];
  assign int_req           = q.int_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_poll_alive: assert property (
    q.hold_cnt <= 16'(SCAN_LONG_CYCLES - 1))
    else $error("drive select held longer than the long slot");

  chk_poll_order: assert property (
    $changed(q.drive_sel) |-> q.drive_sel == $past(q.drive_sel) + 2'h1)
    else $error("drive select skipped a drive");

  chk_slot_length: assert property (
    $changed(q.drive_sel) |->
      $past(q.hold_cnt) == (($past(q.drive_sel) == LAST_DRIVE) ?
        16'(SCAN_LONG_CYCLES - 1) : 16'(SCAN_SHORT_CYCLES - 1)))
    else $error("scan slot length wrong");

  chk_ready_irq: assert property (
    (q.slot_cnt == 16'h0000 && q.seen[q.drive_sel] &&
     q.last_ready[q.drive_sel] != rdy) |=> int_req)
    else $error("ready change did not raise interrupt");

  chk_nr_flag: assert property (
    (data_wr && q.phase == PH_CMD && !q.byte_cnt &&
     pwdata[7:0] == OP_SENSE_INT && found) |=>
      q.res0[ST0_NR_BIT] == ~$past(q.last_ready[pick]) &&
      q.res0[7:6] == 2'b11)
    else $error("sense result lacks not-ready flag");

  chk_exec_bits: assert property (
    (data_wr && q.phase == PH_CMD && q.byte_cnt) |=>
      (msr[MSR_DIO_BIT] && !msr[MSR_RQM_BIT])[*2])
    else $error("execution start did not flip status bits");

  chk_invalid_op: assert property (
    (data_wr && q.phase == PH_CMD && !q.byte_cnt &&
     pwdata[7:0] != OP_SENSE_INT && pwdata[7:0] != OP_RECAL) |=>
      q.phase == PH_RESULT && q.res0 == ST0_INVALID && q.res_left == 2'd1)
    else $error("invalid opcode result wrong");

  chk_write_gated: assert property (
    (data_wr && q.phase != PH_CMD) |=> q.byte_cnt == $past(q.byte_cnt))
    else $error("command byte taken while not requested");

  cov_ready_change: cover property (q.slot_cnt == 16'h0000 &&
    q.seen[q.drive_sel] && q.last_ready[q.drive_sel] != rdy);
  cov_exec_done: cover property (q.phase == PH_EXEC ##1 q.phase == PH_CMD);
  cov_result_read: cover property (data_rd && q.phase == PH_RESULT);

endmodule : ready_poll_cmd

// ==== drive_bank.sv ====
/*
  Drive-side model: four drives sharing one ready pin.
  Assumes the select outputs choose which drive answers on the pin.
*/
`timescale 1ns/1ps
module drive_bank (
  input  wire logic       drive_select_low,
  input  wire logic       drive_select_high,
  input  wire logic [3:0] ready_lvl,
  output logic            drive_ready
);
  // Pin shows the ready level of the drive now selected
  assign drive_ready = ready_lvl[{drive_select_high, drive_select_low}];
endmodule : drive_bank

// ==== ready_poll_cmd_test.sv ====
/*
  Self-checking bench for the polling engine and command handshake.
  Assumes drive_bank on the drive side and short scan slots.
*/
`timescale 1ns/1ps
module ready_poll_cmd_test;
  import poll_pkg::*;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
    logic        r;
  } row_t;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  ready_lvl = 4'hf;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, drive_ready, ds_lo, ds_hi, int_req, err;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          t, n;
  logic [1:0]  exp_code [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
  row_t        rows [9] = '{
    '{1'b0, MSR_OFFSET,  8'h00, 8'h80, 1'b0},
    '{1'b0, 12'h00C,     8'h00, 8'h00, 1'b1},
    '{1'b1, 12'h00C,     8'h55, 8'h00, 1'b1},
    '{1'b0, MSR_OFFSET,  8'h00, 8'h80, 1'b0},
    '{1'b1, DATA_OFFSET, 8'h55, 8'h00, 1'b0},
    '{1'b0, MSR_OFFSET,  8'h00, 8'hD0, 1'b0},
    '{1'b0, DATA_OFFSET, 8'h00, 8'h80, 1'b0},
    '{1'b0, MSR_OFFSET,  8'h00, 8'h80, 1'b0},
    '{1'b0, DATA_OFFSET, 8'h00, 8'h00, 1'b0}};

  always #10 pclk = ~pclk;

  ready_poll_cmd #(
    .SCAN_SHORT_CYCLES(20),
    .SCAN_LONG_CYCLES (40),
    .EXEC_CYCLES      (16)
  ) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_ready(drive_ready),
    .drive_select_low(ds_lo), .drive_select_high(ds_hi),
    .int_req(int_req)
  );

  drive_bank u_drives (
    .drive_select_low(ds_lo), .drive_select_high(ds_hi),
    .ready_lvl(ready_lvl), .drive_ready(drive_ready)
  );

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // Setup, access, then release at the edge that takes pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read just after the edge are those the edge sampled
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, {24'h00_0000, e});
  endtask : rchk

  // Host polls the main status before every command byte
  task cmd(input logic [7:0] d);
    rchk(MSR_OFFSET, 8'h80);
    apb(1'b1, DATA_OFFSET, {24'h00_0000, d});
  endtask : cmd

  task do_reset;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'({ds_hi, ds_lo, int_req}), 32'h0000_0000);
    presetn <= 1'b1;
  endtask : do_reset

  initial begin
    do_reset();
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, {24'h00_0000, rows[i].d});
      chk(32'(err), 32'(rows[i].r));
      if (!rows[i].w) chk(rd, {24'h00_0000, rows[i].e});
    end
    do_reset();
    t = 0;
    for (int s = 0; s < 6; s++) begin
      while (t < 10 + 20 * s) begin
        @(negedge pclk);
        t++;
      end
      chk(32'({ds_hi, ds_lo}), 32'(exp_code[s]));
    end
    @(posedge pclk);
    ready_lvl[2] <= 1'b0;
    n = 0;
    while (int_req !== 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(int_req), 32'h0000_0001);
    apb(1'b0, DRIVE_OFFSET, 32'h0000_0000);
    chk(rd & 32'h0000_0ffc, 32'h0000_04b0);
    cmd(OP_SENSE_INT);
    rchk(DATA_OFFSET, 8'hCA);
    rchk(DATA_OFFSET, 8'h00);
    apb(1'b0, DRIVE_OFFSET, 32'h0000_0000);
    chk(rd & 32'h0000_0ffc, 32'h0000_00b0);
    repeat (2) @(negedge pclk);
    chk(32'(int_req), 32'h0000_0000);
    cmd(OP_RECAL);
    cmd(8'h01);
    // A byte written during execution must be ignored
    apb(1'b1, DATA_OFFSET, 32'h0000_0008);
    rchk(MSR_OFFSET, 8'h50);
    repeat (30) @(negedge pclk);
    chk(32'(int_req), 32'h0000_0001);
    cmd(OP_SENSE_INT);
    rchk(DATA_OFFSET, 8'h21);
    rchk(DATA_OFFSET, 8'h00);
    chk(32'(int_req), 32'h0000_0000);
    end_of_test();
  end
endmodule : ready_poll_cmd_test
